// File: hw/efa_pkg.sv
// Shared constants and types of the embedded flash access block
package efa_pkg;

    // Capacity window in KB, chosen per product variant
    localparam int unsigned EFA_CAP_MIN_KB = 512;
    localparam int unsigned EFA_CAP_MAX_KB = 1024;

    // Fixed special areas outside the main array
    localparam logic [31:0] EFA_SEC_BASE   = 32'h0040_0000;
    localparam logic [31:0] EFA_TRIM_BASE  = 32'h0040_2000;
    localparam logic [31:0] EFA_AREA_BYTES = 32'h0000_2000;

    // Sector map: four 8 KB boot sectors, one 32 KB sector, then 64 KB sectors
    localparam logic [31:0] EFA_BOOT_END = 32'h0000_8000;
    localparam logic [31:0] EFA_MID_END  = 32'h0001_0000;
    localparam logic [4:0]  EFA_SA_BOOT0 = 5'h04;
    localparam logic [4:0]  EFA_SA_MID   = 5'h08;

    // Access width field encodings and its value after reset
    localparam logic [1:0] EFA_WID_WORD = 2'h2;
    localparam logic [1:0] EFA_WID_HALF = 2'h1;
    localparam logic [1:0] EFA_WID_RST  = EFA_WID_WORD;

    // Clock rates in MHz and the read wait states used when too fast
    localparam int unsigned EFA_CLK_MHZ    = 25;
    localparam int unsigned EFA_ZW_MHZ     = 72;
    localparam int unsigned EFA_ACC_MHZ    = 160;
    localparam logic [1:0]  EFA_SLOW_WAIT  = 2'h2;

    // Array geometry
    localparam int unsigned EFA_DW  = 32;
    localparam int unsigned EFA_CW  = 7;
    localparam int unsigned EFA_XW  = EFA_DW + EFA_CW;
    localparam int unsigned EFA_IW  = 18;

    // Request operations
    typedef enum logic [1:0] {
        EFA_OP_READ      = 2'h0,
        EFA_OP_PROG      = 2'h1,
        EFA_OP_ERASE_SEC = 2'h2,
        EFA_OP_ERASE_ALL = 2'h3
    } efa_op_t;

    // Decoded target area
    typedef enum logic [1:0] {
        EFA_AREA_MAIN = 2'h0,
        EFA_AREA_SEC  = 2'h1,
        EFA_AREA_TRIM = 2'h2,
        EFA_AREA_NONE = 2'h3
    } efa_area_t;

    // Controller states, Gray along idle-read and merge-busy-idle
    typedef enum logic [1:0] {
        EFA_ST_IDLE  = 2'h0,
        EFA_ST_READ  = 2'h1,
        EFA_ST_MERGE = 2'h3,
        EFA_ST_BUSY  = 2'h2
    } efa_state_t;

    // Request from the system bus or the external programmer
    typedef struct packed {
        logic        valid;
        efa_op_t     op;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } efa_req_t;

    // Answer to a request
    typedef struct packed {
        logic        valid;
        logic        err;
        logic        fix;
        logic [31:0] rdata;
    } efa_rsp_t;

    // Command toward the array macro
    typedef struct packed {
        logic              rd;
        logic              cmd_valid;
        efa_op_t           op;
        efa_area_t         area;
        logic [EFA_IW-1:0] widx;
        logic [4:0]        sector;
        logic [EFA_XW-1:0] data;
    } efa_arr_t;

endpackage

// File: hw/efa_ecc.sv
// Single-error-correcting check code for one 32-bit array word
`timescale 1ns/1ns

module efa_ecc
(
    // Encoder side
    input  logic [31:0] enc_data_i,
    output logic [6:0]  enc_chk_o,
    // Decoder side
    input  logic [38:0] dec_word_i,
    output logic [31:0] dec_data_o,
    output logic        dec_fix_o
);

    // Codeword position of data bit idx, skipping power-of-two slots
    function automatic logic [5:0] bit_pos(input int unsigned idx);
        int unsigned p;
        int unsigned n;
        p = 0;
        n = 0;
        for (int unsigned q = 3; q < 64; q++)
        begin
            if ((q & (q - 1)) != 0)
            begin
                if (n == idx)
                    p = q;
                n++;
            end
        end
        return p[5:0];
    endfunction

    // Data bits covered by check bit j
    function automatic logic [31:0] mask_of(input int unsigned j);
        logic [31:0] m;
        logic [5:0]  p;
        m = 32'h0000_0000;
        for (int unsigned i = 0; i < 32; i++)
        begin
            p = bit_pos(i);
            m[i] = p[j];
        end
        return m;
    endfunction

    logic [5:0] syn;
    logic [5:0] hchk;

    // check bits
    // Six parity bits per word, computed on every write
    for (genvar j = 0; j < 6; j++)
    begin : g_chk
        localparam logic [31:0] MASK = mask_of(j);
        assign hchk[j] = ^(enc_data_i & MASK);
        assign syn[j]  = ^(dec_word_i[31:0] & MASK) ^ dec_word_i[32 + j];
    end

    // Seventh bit is overall parity; stored but never checked
    assign enc_chk_o = {^{enc_data_i, hchk}, hchk};

    // single correction
    // A syndrome that points at a data slot flips that bit
    for (genvar i = 0; i < 32; i++)
    begin : g_fix
        localparam logic [5:0] POS = bit_pos(i);
        assign dec_data_o[i] = dec_word_i[i] ^ (syn == POS);
    end

    // no double detect
    // Two flipped bits give a wrong syndrome and pass silently
    assign dec_fix_o = |syn;

endmodule

// File: hw/efa_ctrl.sv
// Access controller for the embedded code flash array with check-code handling
`timescale 1ns/1ns

module efa_ctrl
#(
    parameter int unsigned CAP_KB = efa_pkg::EFA_CAP_MAX_KB
)
(
    // Clock and reset
    input  logic                      mclk_i,
    input  logic                      nrst_i,
    // Request and answer
    input  efa_pkg::efa_req_t         req_i,
    output logic                      req_ready_o,
    output efa_pkg::efa_rsp_t         rsp_o,
    // Mode control
    input  logic [1:0]                access_width_sel_i,
    input  logic                      access_width_wr_i,
    input  logic                      accel_en_i,
    input  logic                      ext_prog_i,
    output logic [1:0]                flash_access_width_reg_o,
    output logic                      prog_mode_o,
    // Array macro
    output efa_pkg::efa_arr_t         arr_o,
    input  logic [efa_pkg::EFA_XW-1:0] arr_rdata_i,
    input  logic                      arr_done_i
);

    localparam logic [31:0] CAP_BYTES = 32'(CAP_KB * 1024);
    // wait states
    // Slow reads only when the clock outruns the zero-wait limit
    localparam logic [1:0] WAIT_FIX = (efa_pkg::EFA_CLK_MHZ <= efa_pkg::EFA_ZW_MHZ) ? 2'h0 :
                                      (efa_pkg::EFA_CLK_MHZ <= efa_pkg::EFA_ACC_MHZ) ? 2'h3 : efa_pkg::EFA_SLOW_WAIT;
    localparam int RD_LAT = 3 + int'(WAIT_FIX == 2'h0 ? 2'h0 : efa_pkg::EFA_SLOW_WAIT);

    efa_pkg::efa_state_t state_ff;
    efa_pkg::efa_state_t nxt_state;
    logic [1:0]          wid_ff;
    logic                ext_ff;
    logic                rdy_ff;
    efa_pkg::efa_rsp_t   rsp_ff;
    efa_pkg::efa_rsp_t   nxt_rsp;
    efa_pkg::efa_arr_t   arr_ff;
    efa_pkg::efa_arr_t   nxt_arr;
    logic [1:0]          wcnt_ff;
    logic                a1_ff;
    logic                word_ff;
    logic [15:0]         hw_ff;
    logic                prog_ff;

    // Mode decode
    wire rom_mode  = !ext_ff && (wid_ff == efa_pkg::EFA_WID_WORD);
    wire prog_mode = ext_ff || (wid_ff == efa_pkg::EFA_WID_HALF);
    wire [1:0] wait_st = (WAIT_FIX == 2'h3) ? (accel_en_i ? 2'h0 : efa_pkg::EFA_SLOW_WAIT) : WAIT_FIX;

    // area decode
    // Special areas sit outside the main range, each one page long
    wire [31:0] addr     = req_i.addr;
    wire        in_main  = addr < CAP_BYTES;
    wire        in_sec   = (addr >= efa_pkg::EFA_SEC_BASE) &&
                           (addr < efa_pkg::EFA_SEC_BASE + efa_pkg::EFA_AREA_BYTES);
    wire        in_trim  = (addr >= efa_pkg::EFA_TRIM_BASE) &&
                           (addr < efa_pkg::EFA_TRIM_BASE + efa_pkg::EFA_AREA_BYTES);
    wire efa_pkg::efa_area_t area = in_main ? efa_pkg::EFA_AREA_MAIN :
                                    in_sec  ? efa_pkg::EFA_AREA_SEC  :
                                    in_trim ? efa_pkg::EFA_AREA_TRIM : efa_pkg::EFA_AREA_NONE;
    wire [efa_pkg::EFA_IW-1:0] widx = in_main ? addr[19:2] : {7'h00, addr[12:2]};

    // sector map
    // Boot sectors first so small erases stay cheap during boot updates
    wire [4:0] sector = (addr < efa_pkg::EFA_BOOT_END) ? efa_pkg::EFA_SA_BOOT0 + {3'h0, addr[14:13]} :
                        (addr < efa_pkg::EFA_MID_END)  ? efa_pkg::EFA_SA_MID :
                        efa_pkg::EFA_SA_MID + {1'b0, addr[19:16]};

    // Request classification
    wire acc       = req_i.valid && rdy_ff;
    wire is_read   = req_i.op == efa_pkg::EFA_OP_READ;
    wire is_word   = req_i.size == efa_pkg::EFA_WID_WORD;
    wire is_half   = req_i.size == efa_pkg::EFA_WID_HALF;
    // size check
    // Read-only mode takes words only, programming modes take half-words only
    wire size_ok   = rom_mode ? is_word : is_half;
    wire ign       = !is_read && rom_mode;
    wire refuse    = (area == efa_pkg::EFA_AREA_NONE) || (!ign && !size_ok);
    wire go_read   = acc && !refuse && is_read;
    wire go_prog   = acc && !refuse && !ign && (req_i.op == efa_pkg::EFA_OP_PROG);
    wire go_erase  = acc && !refuse && !ign && !is_read && (req_i.op != efa_pkg::EFA_OP_PROG);
    wire quick     = acc && (refuse || ign);

    // Array data is ready one cycle after the read strobe plus any wait states
    wire take      = !arr_ff.rd && (wcnt_ff == 2'h0);

    logic [31:0] cor_data;
    logic        cor_fix;
    logic [6:0]  new_chk;

    // half-word merge
    // The untouched half comes from the corrected word so a stored bad bit is not rewritten
    wire [31:0] merged = a1_ff ? {hw_ff, cor_data[15:0]} : {cor_data[31:16], hw_ff};
    wire [31:0] rd_out = word_ff ? cor_data : {16'h0000, a1_ff ? cor_data[31:16] : cor_data[15:0]};

    efa_ecc u_ecc
    (
        .enc_data_i (merged),
        .enc_chk_o  (new_chk),
        .dec_word_i (arr_rdata_i),
        .dec_data_o (cor_data),
        .dec_fix_o  (cor_fix)
    );

    // Next state, answer and array command
    always_comb
    begin
        nxt_state = state_ff;
        nxt_rsp   = '0;
        nxt_arr   = arr_ff;
        nxt_arr.rd        = 1'b0;
        nxt_arr.cmd_valid = 1'b0;
        case (state_ff)
            efa_pkg::EFA_ST_IDLE:
            begin
                nxt_arr.op     = req_i.op;
                nxt_arr.area   = area;
                nxt_arr.widx   = widx;
                nxt_arr.sector = sector;
                if (quick)
                begin
                    nxt_rsp.valid = 1'b1;
                    nxt_rsp.err   = refuse;
                end
                else if (go_read || go_prog)
                begin
                    nxt_arr.rd = 1'b1;
                    nxt_state  = go_read ? efa_pkg::EFA_ST_READ : efa_pkg::EFA_ST_MERGE;
                end
                else if (go_erase)
                begin
                    nxt_arr.cmd_valid = 1'b1;
                    nxt_state         = efa_pkg::EFA_ST_BUSY;
                end
            end
            // corrected read
            // Same latency with or without a correction
            efa_pkg::EFA_ST_READ:
            begin
                if (take)
                begin
                    nxt_rsp.valid = 1'b1;
                    nxt_rsp.fix   = cor_fix;
                    nxt_rsp.rdata = rd_out;
                    nxt_state     = efa_pkg::EFA_ST_IDLE;
                end
            end
            efa_pkg::EFA_ST_MERGE:
            begin
                if (take)
                begin
                    nxt_arr.cmd_valid = 1'b1;
                    nxt_arr.data      = {new_chk, merged};
                    nxt_state         = efa_pkg::EFA_ST_BUSY;
                end
            end
            default:
            begin
                if (arr_done_i)
                begin
                    nxt_rsp.valid = 1'b1;
                    nxt_state     = efa_pkg::EFA_ST_IDLE;
                end
            end
        endcase
    end

    // State, answer and array registers
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            state_ff <= efa_pkg::EFA_ST_IDLE;
            rsp_ff   <= '0;
            arr_ff   <= '0;
            rdy_ff   <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            rsp_ff   <= nxt_rsp;
            arr_ff   <= nxt_arr;
            rdy_ff   <= nxt_state == efa_pkg::EFA_ST_IDLE;
        end
    end

    // Wait counter loaded at accept, counted down once the strobe has dropped
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
            wcnt_ff <= 2'h0;
        else if (acc)
            wcnt_ff <= wait_st;
        else if (!arr_ff.rd && (wcnt_ff != 2'h0))
            wcnt_ff <= wcnt_ff - 2'h1;
    end

    // Request details kept for the answer and the merge
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            a1_ff   <= 1'b0;
            word_ff <= 1'b0;
            hw_ff   <= 16'h0000;
        end
        else if (acc)
        begin
            a1_ff   <= addr[1];
            word_ff <= is_word;
            hw_ff   <= req_i.wdata[15:0];
        end
    end

    // access width field
    // Reset always lands in read-only mode; a change mid-operation only affects later requests
    wire       wid_legal = (access_width_sel_i == efa_pkg::EFA_WID_WORD) ||
                           (access_width_sel_i == efa_pkg::EFA_WID_HALF);
    wire [1:0] nxt_wid   = (access_width_wr_i && wid_legal) ? access_width_sel_i : wid_ff;

    // Mode flag built from next values so the output pin has no gate after its flop
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            wid_ff  <= efa_pkg::EFA_WID_RST;
            prog_ff <= 1'b0;
        end
        else
        begin
            wid_ff  <= nxt_wid;
            prog_ff <= ext_prog_i || (nxt_wid == efa_pkg::EFA_WID_HALF);
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
            ext_ff <= 1'b0;
        else
            ext_ff <= ext_prog_i;
    end

    // Outputs straight from registers
    assign req_ready_o              = rdy_ff;
    assign rsp_o                    = rsp_ff;
    assign arr_o                    = arr_ff;
    assign flash_access_width_reg_o = wid_ff;
    assign prog_mode_o              = prog_ff;

    // Checks
    // reset mode
    a_rst_rom_mode: assert property (@(posedge mclk_i) $rose(nrst_i) |-> wid_ff == efa_pkg::EFA_WID_WORD)
        else $error("width field not word after reset");
    a_rom_no_alg: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (acc && ign) |=> (!arr_ff.cmd_valid && !arr_ff.rd && rsp_ff.valid && !rsp_ff.err) ##1 !arr_ff.cmd_valid)
        else $error("write in read-only mode reached the array");
    a_prog_word_ref: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (acc && prog_mode && is_word) |=> rsp_ff.valid && rsp_ff.err)
        else $error("word access in programming mode not refused");
    a_read_latency: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        go_read |-> ##RD_LAT (rsp_ff.valid && !rsp_ff.err))
        else $error("read answer not at fixed latency");
    a_prog_launch: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        go_prog |-> ##[3:5] (arr_ff.cmd_valid && arr_ff.op == efa_pkg::EFA_OP_PROG))
        else $error("program not issued in time");
    a_erase_issue: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        go_erase |=> arr_ff.cmd_valid && arr_ff.op == $past(req_i.op) && state_ff == efa_pkg::EFA_ST_BUSY)
        else $error("erase not launched");
    a_area_decode: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (go_read && addr[31:13] == efa_pkg::EFA_TRIM_BASE[31:13]) |=> arr_ff.area == efa_pkg::EFA_AREA_TRIM)
        else $error("trim area not decoded");
    a_boot_sector: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (go_erase && addr < efa_pkg::EFA_BOOT_END) |=> arr_ff.sector == 5'h04 + {3'h0, $past(addr[14:13])})
        else $error("boot sector index wrong");
    a_wid_select: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (access_width_wr_i && access_width_sel_i == efa_pkg::EFA_WID_HALF) |=> prog_mode_o)
        else $error("half width did not select programming mode");

    // Main scenarios
    c_read_ok:   cover property (@(posedge mclk_i) disable iff (!nrst_i) go_read ##RD_LAT rsp_ff.valid);
    c_read_fix:  cover property (@(posedge mclk_i) disable iff (!nrst_i) rsp_ff.valid && rsp_ff.fix);
    c_prog_done: cover property (@(posedge mclk_i) disable iff (!nrst_i) go_prog ##[3:20] rsp_ff.valid);
    c_refused:   cover property (@(posedge mclk_i) disable iff (!nrst_i) rsp_ff.valid && rsp_ff.err);

endmodule

// File: dv/efa_arr_model.sv
// Behavioural model of the flash array macro behind the access controller
`timescale 1ns/1ns

module efa_arr_model
(
    // Clock
    input  logic                       mclk_i,
    // Command in, read word and completion out
    input  efa_pkg::efa_arr_t          arr_i,
    output logic [efa_pkg::EFA_XW-1:0] rdata_o,
    output logic                       done_o
);
    logic [efa_pkg::EFA_XW-1:0] mem [logic [19:0]];
    logic [4:0]                 sec_of [logic [19:0]];
    logic [efa_pkg::EFA_XW-1:0] flip = '0;
    int                         done_dly = 0;
    int                         n_cmd = 0;
    int                         cnt = 0;
    efa_pkg::efa_op_t           last_op;
    efa_pkg::efa_area_t         last_area;
    logic [4:0]                 last_sector;
    logic [19:0]                key;
    logic [19:0]                drop [$];

    // Area and word index together address one stored word
    assign key = {arr_i.area, arr_i.widx};

    initial
    begin
        rdata_o = '0;
        done_o = 1'b0;
    end

    // Read word valid one cycle only; otherwise it toggles so stale data never looks good
    always @(posedge mclk_i)
    begin
        done_o <= (cnt == 1) || (arr_i.cmd_valid && done_dly == 0);
        rdata_o <= ~rdata_o;
        if (cnt > 0)
            cnt <= cnt - 1;
        if (arr_i.rd)
            rdata_o <= (mem.exists(key) ? mem[key] : '1) ^ flip;
        if (arr_i.cmd_valid)
        begin
            n_cmd <= n_cmd + 1;
            cnt <= done_dly;
            last_op <= arr_i.op;
            last_area <= arr_i.area;
            last_sector <= arr_i.sector;
            if (arr_i.op == efa_pkg::EFA_OP_PROG)
            begin
                mem[key] = arr_i.data;
                sec_of[key] = arr_i.sector;
            end
            else if (arr_i.op == efa_pkg::EFA_OP_ERASE_ALL)
            begin
                mem.delete();
                sec_of.delete();
            end
            else if (arr_i.op == efa_pkg::EFA_OP_ERASE_SEC)
            begin
                drop = {};
                foreach (sec_of[k])
                    if (sec_of[k] == arr_i.sector)
                        drop.push_back(k);
                foreach (drop[j])
                begin
                    mem.delete(drop[j]);
                    sec_of.delete(drop[j]);
                end
            end
        end
    end
endmodule

// File: dv/tb_top.sv
// Self-checking bench for the flash access controller
`timescale 1ns/1ns

module tb_top;
    logic                       mclk_i = 1'b0;
    logic                       nrst_i = 1'b0;
    efa_pkg::efa_req_t          req_i = '0;
    logic                       req_ready_o;
    efa_pkg::efa_rsp_t          rsp_o;
    logic [1:0]                 access_width_sel_i = 2'h0;
    logic                       access_width_wr_i = 1'b0;
    logic                       accel_en_i = 1'b0;
    logic                       ext_prog_i = 1'b0;
    logic [1:0]                 flash_access_width_reg_o;
    logic                       prog_mode_o;
    efa_pkg::efa_arr_t          arr_o;
    logic [efa_pkg::EFA_XW-1:0] arr_rdata_i;
    logic                       arr_done_i;
    efa_pkg::efa_rsp_t          r;
    int                         lat;
    int                         n_mismatch = 0;
    int                         samples_checked = 0;

    always #20 mclk_i = ~mclk_i;

    efa_ctrl #(.CAP_KB(1024)) i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .req_i(req_i), .req_ready_o(req_ready_o),
        .rsp_o(rsp_o), .access_width_sel_i(access_width_sel_i), .access_width_wr_i(access_width_wr_i),
        .accel_en_i(accel_en_i), .ext_prog_i(ext_prog_i), .flash_access_width_reg_o(flash_access_width_reg_o),
        .prog_mode_o(prog_mode_o), .arr_o(arr_o), .arr_rdata_i(arr_rdata_i), .arr_done_i(arr_done_i));

    efa_arr_model i_arr (.mclk_i(mclk_i), .arr_i(arr_o), .rdata_o(arr_rdata_i), .done_o(arr_done_i));

    task automatic tally_and_finish();
        $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input string what, input logic [38:0] seen, input logic [38:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    // Request held until taken; latency counts edges from the take edge, as 1, to the edge that registers the answer
    task automatic xfer(input efa_pkg::efa_op_t op, input logic [1:0] sz, input logic [31:0] a,
                        input logic [15:0] wd);
        int k;
        k = 0;
        req_i = '{1'b1, op, sz, a, {16'h0000, wd}};
        // Ready seen between edges is the value the next edge samples
        while (!req_ready_o && k < 50)
        begin
            tick(1);
            k++;
        end
        tick(1);
        req_i = '0;
        lat = 1;
        while (rsp_o.valid !== 1'b1 && lat < 60)
        begin
            tick(1);
            lat++;
        end
        r = rsp_o;
        if (k >= 50 || lat >= 60)
        begin
            n_mismatch++;
            $display("BAD handshake expected answer seen none");
            tally_and_finish();
        end
        // Let an edge pass so the next request never re-raises valid in this step
        tick(1);
    endtask

    task automatic set_width(input logic [1:0] v);
        access_width_sel_i = v;
        access_width_wr_i = 1'b1;
        tick(1);
        access_width_wr_i = 1'b0;
        tick(1);
    endtask

    task automatic do_reset();
        nrst_i = 1'b0;
        tick(6);
        nrst_i = 1'b1;
        tick(2);
        check("width", flash_access_width_reg_o, efa_pkg::EFA_WID_WORD);
        check("pmode", prog_mode_o, 1'b0);
    endtask

    task automatic sc_rom_refuse();
        int n0;
        n0 = i_arr.n_cmd;
        for (int i = 1; i < 4; i++)
        begin
            xfer(efa_pkg::efa_op_t'(i), 2'h1, 32'h0000_0100, 16'h1234);
            check("ign err", {r.err, lat[3:0]}, {1'b0, 4'h1});
        end
        check("ign cmds", i_arr.n_cmd - n0, 0);
        xfer(efa_pkg::EFA_OP_READ, 2'h1, 32'h0000_0100, 16'h0);
        check("half ro", {r.err, lat[3:0]}, {1'b1, 4'h1});
    endtask

    task automatic sc_program();
        set_width(efa_pkg::EFA_WID_HALF);
        check("pmode", {flash_access_width_reg_o, prog_mode_o}, 3'b011);
        set_width(2'h3);
        check("illegal", flash_access_width_reg_o, 2'h1);
        xfer(efa_pkg::EFA_OP_READ, 2'h2, 32'h0000_0100, 16'h0);
        check("word pm", r.err, 1'b1);
        xfer(efa_pkg::EFA_OP_PROG, 2'h1, 32'h0000_0100, 16'ha5c3);
        check("prog lo", r.err, 1'b0);
        i_arr.done_dly = 6;
        xfer(efa_pkg::EFA_OP_PROG, 2'h1, 32'h0000_0102, 16'h5a3c);
        i_arr.done_dly = 0;
        check("prog hi", r.err, 1'b0);
        check("stored", i_arr.mem[20'h00040][31:0], 32'h5a3c_a5c3);
        xfer(efa_pkg::EFA_OP_READ, 2'h1, 32'h0000_0102, 16'h0);
        check("half hi", {r.err, r.rdata}, {1'b0, 32'h0000_5a3c});
    endtask

    // Single flips corrected at equal latency, double flips pass silently
    task automatic sc_word_ecc();
        logic [38:0] flips [4] = '{39'h0, 39'h1 << 17, 39'h1 << 35, 39'h3};
        set_width(efa_pkg::EFA_WID_WORD);
        check("rom mode", {flash_access_width_reg_o, prog_mode_o}, 3'b100);
        foreach (flips[i])
        begin
            i_arr.flip = flips[i];
            accel_en_i = i[0];
            xfer(efa_pkg::EFA_OP_READ, 2'h2, 32'h0000_0100, 16'h0);
            check("rd lat", lat, 3);
            check("rd err", r.err, 1'b0);
            if (i < 3)
                check("rd data", r.rdata, 32'h5a3c_a5c3);
            else
                check("dbl data", r.rdata == 32'h5a3c_a5c3, 1'b0);
            if (i == 1)
                check("fix", r.fix, 1'b1);
        end
        i_arr.flip = '0;
        accel_en_i = 1'b0;
    endtask

    task automatic sc_areas();
        set_width(efa_pkg::EFA_WID_HALF);
        xfer(efa_pkg::EFA_OP_PROG, 2'h1, 32'h0040_0000, 16'h00c3);
        check("sec area", {r.err, i_arr.last_area}, {1'b0, efa_pkg::EFA_AREA_SEC});
        xfer(efa_pkg::EFA_OP_PROG, 2'h1, 32'h0040_2002, 16'h7e81);
        check("trim area", {r.err, i_arr.last_area}, {1'b0, efa_pkg::EFA_AREA_TRIM});
        xfer(efa_pkg::EFA_OP_READ, 2'h1, 32'h0040_2002, 16'h0);
        check("trim rd", {r.err, r.rdata}, {1'b0, 32'h0000_7e81});
        xfer(efa_pkg::EFA_OP_READ, 2'h1, 32'h0040_4000, 16'h0);
        check("past trim", r.err, 1'b1);
        xfer(efa_pkg::EFA_OP_READ, 2'h1, 32'h0010_0000, 16'h0);
        check("past cap", r.err, 1'b1);
        xfer(efa_pkg::EFA_OP_READ, 2'h1, 32'h000f_fffe, 16'h0);
        check("top word", r.err, 1'b0);
    endtask

    task automatic sc_external();
        set_width(efa_pkg::EFA_WID_WORD);
        ext_prog_i = 1'b1;
        tick(2);
        check("ext mode", prog_mode_o, 1'b1);
        xfer(efa_pkg::EFA_OP_PROG, 2'h1, 32'h0000_0200, 16'hbeef);
        check("ext prog", {r.err, i_arr.mem[20'h00080][15:0]}, {1'b0, 16'hbeef});
        ext_prog_i = 1'b0;
        tick(2);
    endtask

    task automatic sc_erase();
        logic [31:0] ea [4] = '{32'h0000_0100, 32'h0000_8000, 32'h0002_0000, 32'h000f_0000};
        logic [4:0]  es [4] = '{5'h04, 5'h08, 5'h0a, 5'h17};
        set_width(efa_pkg::EFA_WID_HALF);
        i_arr.done_dly = 4;
        foreach (ea[i])
        begin
            xfer(efa_pkg::EFA_OP_ERASE_SEC, 2'h1, ea[i], 16'h0);
            check("sector", {r.err, i_arr.last_op, i_arr.last_sector}, {1'b0, 2'h2, es[i]});
        end
        check("erased", i_arr.mem.exists(20'h00040), 1'b0);
        i_arr.done_dly = 0;
        xfer(efa_pkg::EFA_OP_ERASE_ALL, 2'h1, 32'h0000_0000, 16'h0);
        check("all", {r.err, i_arr.last_op, i_arr.mem.num() == 0}, {1'b0, 2'h3, 1'b1});
    endtask

    initial
    begin
        do_reset();
        sc_rom_refuse();
        sc_program();
        sc_word_ecc();
        sc_areas();
        sc_external();
        sc_erase();
        set_width(efa_pkg::EFA_WID_HALF);
        do_reset();
        tally_and_finish();
    end
endmodule
